/* include/fpes_consts.vh */
/*
  Constants for the flash program/erase/security sequencer.
  Assumes a 14-bit CPU address space with 8-bit data.
*/
`ifndef FPES_CONSTS_VH
`define FPES_CONSTS_VH

`define FPES_ADDR_OPT_WORK   14'h0210
`define FPES_ADDR_FLASH_CTL  14'h0211
`define FPES_ADDR_OPT_NV     14'h3FFC
`define FPES_ADDR_PAGE_SEL   14'h001F
`define FPES_WIN_LO          8'hC0
`define FPES_WIN_HI          8'hFF
`define FPES_FLASH_LO        14'h3800
`define FPES_ROW_BYTES       64
`define FPES_ROW_LSB         6
`define FPES_BIT_PGM         0
`define FPES_BIT_MASS        2
`define FPES_BIT_HIGH_VOLTAGE_ENABLE        3
`define FPES_BIT_SECURITY_BIT        0
`define FPES_CTL_RST         8'h00
`define FPES_PAGE_RST        8'h00

`endif

/* design/fpes_flash_seq.v */
/*
  Flash program / mass-erase sequencer with security state.
  Holds the flash control register, the working option register and the page
  select register, and steers the array's program and erase strobes.
  Assumes an 8-bit CPU/debug bus with one-cycle read and write strobes, a
  nonvolatile option byte presented by the array, and software that times
  every interval itself.
*/
`timescale 1ns/1ns
`include "fpes_consts.vh"

module fpes_flash_seq #(
  parameter AW = 14,
  parameter DW = 8
) (
  input  wire          clock_i,
  input  wire          arst_n_i,
  input  wire [AW-1:0] bus_addr_i,
  input  wire [DW-1:0] bus_wdata_i,
  input  wire          bus_wr_i,
  input  wire          bus_rd_i,
  input  wire          bus_from_debug_i,
  input  wire [DW-1:0] array_rdata_i,
  input  wire [DW-1:0] nonvolatile_option_byte_i,
  input  wire          boot_mode_pin_i,
  input  wire          debug_pin_enable_i,
  input  wire          programming_supply_i,
  output reg  [DW-1:0] bus_rdata_o,
  output reg           debug_blocked_o,
  output reg           secured_o,
  output reg  [AW-1:0] latch_addr_o,
  output reg  [DW-1:0] latch_data_o,
  output reg           prog_strobe_o,
  output reg           high_voltage_o,
  output reg           erase_mode_o,
  output reg           program_mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg [DW-1:0] page_select_ff;
  reg          program_select_ff;
  reg          mass_select_ff;
  reg          high_voltage_enable_ff;
  reg [3:0]    seq_state_ff;
  reg          option_loaded_ff;
  reg          security_bit_ff;
  reg          boot_mode_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire in_window   = (bus_addr_i[AW-1:8] == 0) && (bus_addr_i[7:0] >= `FPES_WIN_LO);
  // Window offset within the row, page bits on top
  wire [AW-1:0] win_addr = {page_select_ff, bus_addr_i[`FPES_ROW_LSB-1:0]};
  wire [AW-1:0] eff_addr = in_window ? win_addr : bus_addr_i;
  wire is_flash    = (eff_addr >= `FPES_FLASH_LO);
  wire secured     = ~security_bit_ff;
  // Debug pin enable counts as a debug path when secured
  wire flash_block = secured & (bus_from_debug_i | debug_pin_enable_i);
  wire hit_ctl     = bus_addr_i == `FPES_ADDR_FLASH_CTL;
  wire hit_opt     = bus_addr_i == `FPES_ADDR_OPT_WORK;
  wire hit_page    = bus_addr_i == `FPES_ADDR_PAGE_SEL;
  wire dbg_ok      = ~(boot_mode_ff & secured) | ~bus_from_debug_i;

  ////////////////////////////////////////////////////////////////////////////
  // Write qualifiers
  wire wr_ctl    = bus_wr_i && hit_ctl && dbg_ok;
  wire want_pgm  = bus_wdata_i[`FPES_BIT_PGM];
  wire want_mass = bus_wdata_i[`FPES_BIT_MASS];
  wire want_hv   = bus_wdata_i[`FPES_BIT_HIGH_VOLTAGE_ENABLE];
  wire flash_wr  = bus_wr_i && is_flash && dbg_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Sequence tracker states
  localparam [3:0] SEQ_IDLE   = 4'b0001;
  localparam [3:0] SEQ_SELECT = 4'b0010;
  localparam [3:0] SEQ_ARMED  = 4'b0100;
  localparam [3:0] SEQ_HIGH   = 4'b1000;

  reg          nxt_pgm;
  reg          nxt_mass;
  reg          nxt_hv;
  reg [3:0]    nxt_seq_state;
  wire         seq_armed  = (seq_state_ff == SEQ_ARMED);
  wire         any_select = nxt_pgm | nxt_mass;
  // The mass erase dummy write may hit secured flash: it only arms the
  // sequence and never reaches the array, so debug can still erase unless boot mode blocks its bus
  wire         arm_write  = flash_wr &&
                            (mass_select_ff | (program_select_ff & ~flash_block));

  ////////////////////////////////////////////////////////////////////////////
  // Flash control next state
  always @* begin
    nxt_pgm  = program_select_ff;
    nxt_mass = mass_select_ff;
    nxt_hv   = high_voltage_enable_ff;
    if (wr_ctl) begin
      // Setting one select while the other is held is refused
      if (!want_pgm) begin
        nxt_pgm = 1'b0;
      end else if (!secured && !mass_select_ff && !want_mass) begin
        nxt_pgm = 1'b1;
      end
      if (!want_mass) begin
        nxt_mass = 1'b0;
      end else if (!program_select_ff && !want_pgm) begin
        nxt_mass = 1'b1;
      end
      if (!want_hv) begin
        nxt_hv = 1'b0;
      end else if ((program_select_ff | mass_select_ff) && seq_armed) begin
        nxt_hv = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence tracker
  // High voltage is only granted from the armed step, so a select followed
  // directly by a high-voltage write never reaches the array
  always @* begin
    nxt_seq_state = seq_state_ff;
    case (seq_state_ff)
      SEQ_IDLE: begin
        if (any_select) begin
          nxt_seq_state = SEQ_SELECT;
        end
      end
      SEQ_SELECT: begin
        if (!any_select) begin
          nxt_seq_state = SEQ_IDLE;
        end else if (arm_write) begin
          nxt_seq_state = SEQ_ARMED;
        end
      end
      SEQ_ARMED: begin
        if (!any_select) begin
          nxt_seq_state = SEQ_IDLE;
        end else if (nxt_hv) begin
          nxt_seq_state = SEQ_HIGH;
        end
      end
      SEQ_HIGH: begin
        // Selects drop before high voltage, so wait for the voltage to go
        if (!nxt_hv) begin
          if (any_select) begin
            nxt_seq_state = SEQ_ARMED;
          end else begin
            nxt_seq_state = SEQ_IDLE;
          end
        end
      end
      default: begin
        nxt_seq_state = SEQ_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection
  reg [DW-1:0] nxt_rdata;
  always @* begin
    nxt_rdata = {DW{1'b0}};
    if (bus_rd_i && dbg_ok) begin
      if (hit_opt) begin
        nxt_rdata = {7'h00, security_bit_ff};
      end else if (hit_ctl) begin
        nxt_rdata = {4'h0, high_voltage_enable_ff, mass_select_ff,
                     1'b0, program_select_ff};
      end else if (hit_page) begin
        nxt_rdata = page_select_ff;
      end else if (is_flash && !flash_block) begin
        nxt_rdata = array_rdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option capture
  // The byte is looked at once per reset; a new value waits for the next one
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      option_loaded_ff <= 1'b0;
      security_bit_ff  <= 1'b0; // Secure until the option byte is copied
      boot_mode_ff     <= 1'b0;
    end else if (!option_loaded_ff) begin
      option_loaded_ff <= 1'b1;
      security_bit_ff  <= nonvolatile_option_byte_i[`FPES_BIT_SECURITY_BIT];
      boot_mode_ff     <= boot_mode_pin_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page select
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      page_select_ff <= `FPES_PAGE_RST;
    end else if (bus_wr_i && hit_page && dbg_ok) begin
      page_select_ff <= bus_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits and sequence state
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      program_select_ff      <= 1'b0;
      mass_select_ff         <= 1'b0;
      high_voltage_enable_ff <= 1'b0;
      seq_state_ff           <= SEQ_IDLE;
    end else begin
      program_select_ff      <= nxt_pgm;
      mass_select_ff         <= nxt_mass;
      high_voltage_enable_ff <= nxt_hv;
      seq_state_ff           <= nxt_seq_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program latch
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_addr_o  <= {AW{1'b0}};
      latch_data_o  <= {DW{1'b0}};
      prog_strobe_o <= 1'b0;
    end else begin
      prog_strobe_o <= 1'b0;
      // Byte address latched on every unblocked flash write with program selected, first and later ones alike
      if (flash_wr && !flash_block && program_select_ff) begin
        latch_addr_o  <= eff_addr;
        latch_data_o  <= bus_wdata_i;
        // Without the supply the array cannot program, so no strobe is sent
        prog_strobe_o <= high_voltage_enable_ff & programming_supply_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode outputs
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      high_voltage_o <= 1'b0;
      erase_mode_o   <= 1'b0;
      program_mode_o <= 1'b0;
    end else begin
      high_voltage_o <= high_voltage_enable_ff & programming_supply_i;
      erase_mode_o   <= mass_select_ff;
      program_mode_o <= program_select_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Security outputs
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      secured_o       <= 1'b1;
      debug_blocked_o <= 1'b0;
    end else begin
      secured_o       <= secured;
      debug_blocked_o <= boot_mode_ff & secured;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data register
  // Zero whenever nothing is read, so blocked reads look like idle cycles
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_rdata_o <= {DW{1'b0}};
    end else begin
      bus_rdata_o <= nxt_rdata;
    end
  end

endmodule // fpes_flash_seq

/* testbench/fpes_flash_seq_asserts.sv */
/* Port checker for the flash sequencer.
   Assumes binding to fpes_flash_seq with matching port names. */
`timescale 1ns/1ns
module fpes_flash_seq_asserts (
  input wire        clock_i, arst_n_i, bus_rd_i, bus_from_debug_i, debug_pin_enable_i,
  input wire        programming_supply_i, debug_blocked_o, secured_o, prog_strobe_o,
  input wire        high_voltage_o, erase_mode_o, program_mode_o,
  input wire [13:0] bus_addr_i,
  input wire [7:0]  bus_rdata_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_opt_rd; bus_rd_i && bus_addr_i == 14'h0210 && !bus_from_debug_i; endsequence
  sequence s_blk_rd;
    bus_rd_i && bus_addr_i >= 14'h3800 && secured_o && (bus_from_debug_i || debug_pin_enable_i);
  endsequence
  property p_opt; s_opt_rd |=> bus_rdata_o == {7'h00, !secured_o}; endproperty
  property p_blk; s_blk_rd |=> bus_rdata_o == 8'h00; endproperty
  property p_idle; !bus_rd_i |=> bus_rdata_o == 8'h00; endproperty
  property p_lock; !(program_mode_o && erase_mode_o); endproperty
  property p_hv; $rose(high_voltage_o) |-> program_mode_o || erase_mode_o; endproperty
  property p_sup; high_voltage_o |-> $past(programming_supply_i); endproperty
  property p_stb; prog_strobe_o |-> program_mode_o && high_voltage_o; endproperty
  property p_nopgm; $rose(program_mode_o) |-> !secured_o; endproperty
  property p_dbg; debug_blocked_o |-> secured_o; endproperty
  a_opt: assert property (p_opt) else $error("option read wrong");
  a_blk: assert property (p_blk) else $error("blocked read not zero");
  a_idle: assert property (p_idle) else $error("read data not idle");
  a_lock: assert property (p_lock) else $error("both selects set");
  a_hv: assert property (p_hv) else $error("high voltage without select");
  a_sup: assert property (p_sup) else $error("high voltage without supply");
  a_stb: assert property (p_stb) else $error("strobe outside program");
  a_nopgm: assert property (p_nopgm) else $error("program while secured");
  a_dbg: assert property (p_dbg) else $error("debug blocked unsecured");
endmodule // fpes_flash_seq_asserts
bind fpes_flash_seq fpes_flash_seq_asserts u_chk (.*);

/* testbench/fpes_array_model.sv */
/* Behavioural flash array: 2 KB from 0x3800, option byte at the top.
   Assumes strobes from the sequencer; contents survive reset. */
`timescale 1ns/1ns
module fpes_array_model #(parameter [7:0] OPT_INIT = 8'hFE) (
  input  wire        clock_i,
  input  wire [13:0] addr_i,
  input  wire [13:0] latch_addr_i,
  input  wire [7:0]  latch_data_i,
  input  wire        strobe_i,
  input  wire        erase_i,
  output wire [7:0]  rdata_o,
  output wire [7:0]  option_o
);
  reg [7:0] mem_ff [0:2047];
  integer   k;
  initial begin
    for (k = 0; k < 2048; k = k + 1) mem_ff[k] = 8'hFF;
    mem_ff[11'h7FC] = OPT_INIT;
  end
  always @(posedge clock_i) begin
    if (erase_i) for (k = 0; k < 2048; k = k + 1) mem_ff[k] <= 8'hFF;
    if (strobe_i) mem_ff[latch_addr_i[10:0]] <= mem_ff[latch_addr_i[10:0]] & latch_data_i;
  end
  assign rdata_o  = mem_ff[addr_i[10:0]];
  assign option_o = mem_ff[11'h7FC];
endmodule // fpes_array_model

/* testbench/fpes_flash_seq_tb_top.sv */
/* Self-checking bench: security, mass erase, row program.
   Assumes the array model and the bound checker. */
`timescale 1ns/1ns
module fpes_flash_seq_tb_top;
  logic clock_i = 0, arst_n_i = 0, wr = 0, rd = 0, dbg = 0, boot = 0, dpe = 0, sup = 1, rd_seen = 0;
  logic [13:0] addr = 0, laddr;
  logic [7:0]  wdat = 0, rdat, ardat, opt, ldata, d0, d1, expq[$];
  logic        blk, sec, stb, hv, ers, program_select;
  integer      error_cnt = 0, total_checks = 0, seed = 32'hf2121b46;
  always #25 clock_i = ~clock_i;
  fpes_flash_seq uut (.clock_i(clock_i), .arst_n_i(arst_n_i), .bus_addr_i(addr), .bus_wdata_i(wdat),
    .bus_wr_i(wr), .bus_rd_i(rd), .bus_from_debug_i(dbg), .array_rdata_i(ardat),
    .nonvolatile_option_byte_i(opt), .boot_mode_pin_i(boot), .debug_pin_enable_i(dpe),
    .programming_supply_i(sup), .bus_rdata_o(rdat), .debug_blocked_o(blk), .secured_o(sec),
    .latch_addr_o(laddr), .latch_data_o(ldata), .prog_strobe_o(stb), .high_voltage_o(hv),
    .erase_mode_o(ers), .program_mode_o(program_select));
  fpes_array_model u_arr (.clock_i(clock_i), .addr_i(addr), .latch_addr_i(laddr),
    .latch_data_i(ldata), .strobe_i(stb), .erase_i(hv & ers), .rdata_o(ardat), .option_o(opt));
  task chk(input string nm, input [13:0] seen, input [13:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr_b(input [13:0] a, input [7:0] d);
    @(negedge clock_i); addr = a; wdat = d; wr = 1;
    @(negedge clock_i); wr = 0;
  endtask
  task rd_b(input [13:0] a, input [7:0] e);
    @(negedge clock_i); addr = a; rd = 1; expq.push_back(e);
    @(negedge clock_i); rd = 0;
  endtask
  task rst;
    arst_n_i = 0; repeat (6) @(negedge clock_i);
    arst_n_i = 1; repeat (2) @(negedge clock_i);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////
  always @(posedge clock_i) rd_seen <= rd;
  always @(negedge clock_i) if (rd_seen) chk("rdata", rdat, expq.pop_front());
  initial begin #(5000 * 50); error_cnt++; wrap_up; end
  initial begin
    boot = 1; rst;
    chk("blocked", blk, 1);
    chk("secured", sec, 1);
    dbg = 1; wr_b(14'h0211, 8'h04); dbg = 0; rd_b(14'h0211, 8'h00);
    boot = 0; rst;
    chk("blocked", blk, 0);
    dbg = 1; rd_b(14'h0210, 8'h00); rd_b(14'h3840, 8'h00);
    dbg = 0; dpe = 1; rd_b(14'h3840, 8'h00); dpe = 0; rd_b(14'h3840, 8'hFF);
    wr_b(14'h0211, 8'h01); rd_b(14'h0211, 8'h00);
    dbg = 1; wr_b(14'h0211, 8'h04); wr_b(14'h001F, 8'hE0); wr_b(14'h00C0, 8'h00);
    wr_b(14'h0211, 8'h0C); rd_b(14'h0211, 8'h0C);
    chk("hv", hv, 1);
    chk("erase mode", ers, 1);
    wr_b(14'h0211, 8'h08); wr_b(14'h0211, 8'h00); dbg = 0; rst;
    chk("secured", sec, 0);
    wr_b(14'h0210, 8'h00); rd_b(14'h0210, 8'h01);
    wr_b(14'h0211, 8'h01); wr_b(14'h0211, 8'h09); rd_b(14'h0211, 8'h01);
    wr_b(14'h0211, 8'h05); rd_b(14'h0211, 8'h01);
    wr_b(14'h001F, 8'hE1); wr_b(14'h00C0, 8'h00); wr_b(14'h0211, 8'h09);
    d0 = $random(seed); d1 = $random(seed);
    wr_b(14'h00C0, d0); wr_b(14'h00FF, d1); wr_b(14'h0211, 8'h08); wr_b(14'h0211, 8'h00);
    chk("latch addr", laddr, 14'h387F);
    chk("latch data", ldata, d1);
    rd_b(14'h3840, d0); rd_b(14'h387F, d1); rd_b(14'h3880, 8'hFF);
    @(negedge clock_i); wrap_up;
  end
endmodule // fpes_flash_seq_tb_top
